// ### core/swk_regs.svh
// constants for the sleep, wake and rc trim controller
// Function
// - software arms sleep, then executes sleep
// - depth zero enters idle, cpu halted
// - idle wakes on any interrupt or reset
// - software powers comparator down in idle when unneeded
// - depth one enters power-down, oscillator stops
// - power-down wakes on four sources only
// - interrupt wake halts cpu four cycles
// - sleep and wake keep register contents
// - reset during sleep restarts from vector
// - no-rc variant needs stimulus beyond timeout
// - wake accepted after two watchdog cycles
// - short wake period replaces two cycles
// - vanished condition wakes without running handler
// - wake effective after fuse-chosen start-up delay
// - rc oscillator nominal 1.2 MHz, selectable
// - watchdog oscillator keeps running with rc
// - trim value raises frequency monotonically
// - keep trim within ten percent for nvm
// - arm bit five, depth bit four
`ifndef SWK_REGS_SVH
`define SWK_REGS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define SWK_TRIM_ADDR    6'h31
`define SWK_CTL_ADDR     6'h38
`define SWK_TRIM_RST     8'h00
`define SWK_CTL_ARM_BIT  5
`define SWK_CTL_DEP_BIT  4

// ----------------------------------------------------------------
// timing, counted in watchdog oscillator ticks or mclk cycles; rc rate in kHz, nvm trim limit
// ----------------------------------------------------------------
`define SWK_QUAL_TICKS   11'h002
`define SWK_WAKE_PER0    11'h001
`define SWK_WAKE_PER1    11'h010
`define SWK_WAKE_PER2    11'h100
`define SWK_WAKE_PER3    11'h400
`define SWK_HALT_CYC     3'h4
`define SWK_RC_NOM_KHZ   12'h04B0
`define SWK_TRIM_NVM_MAX 8'h0090

// ----------------------------------------------------------------
// clock source fuse fields
// ----------------------------------------------------------------
`define SWK_FUSE_RC_BIT  2

`endif

// ### core/swk_pkg.sv
// types shared by both ends of the sleep controller link
package swk_pkg;
	typedef enum logic [2:0] {S_RUN, S_IDLE, S_PDOWN, S_QUAL, S_SYNC, S_HALT} swk_dev_st_e;
	typedef enum logic [2:0] {H_READY, H_EXEC, H_WAIT, H_DISARM, H_READ} swk_core_st_e;
	typedef logic [10:0] swk_tick_t;
endpackage

// ### core/swk_if.sv
// link between processor core and sleep controller
interface swk_if;
	logic       io_wr;
	logic       io_rd;
	logic [5:0] io_addr;
	logic [7:0] io_wdata;
	logic [7:0] io_rdata;
	logic       sleep_exec;
	logic       cpu_halt;
	logic       resume_irq;
	logic       resume_plain;
	logic       resume_reset;

	modport dev
	(
		input  io_wr, io_rd, io_addr, io_wdata, sleep_exec,
		output io_rdata, cpu_halt, resume_irq, resume_plain, resume_reset
	);
	modport core
	(
		output io_wr, io_rd, io_addr, io_wdata, sleep_exec,
		input  io_rdata, cpu_halt, resume_irq, resume_plain, resume_reset
	);
endinterface

// ### core/swk_dev.sv
// sleep entry, wake qualification and rc trim register
`include "swk_regs.svh"

module swk_dev
	import swk_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst_b,
	swk_if.dev              bus,
	input  wire logic       ext_level_wake,
	input  wire logic       pin_change_wake,
	input  wire logic       timer_irq,
	input  wire logic       comp_irq,
	input  wire logic       other_irq,
	input  wire logic       ext_reset_req,
	input  wire logic       wdt_reset_req,
	input  wire logic       wdt_enabled,
	input  wire logic       wdt_tick,
	input  wire logic [2:0] clock_source_fuses,
	output logic            ext_osc_en,
	output logic            rc_osc_en,
	output logic            wdt_osc_en,
	output logic            periph_clk_en,
	output logic [7:0]      rc_trim
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	swk_dev_st_e st_r;
	swk_dev_st_e st_nxt;
	swk_tick_t   cnt_r;
	swk_tick_t   cnt_nxt;
	logic        held_r;
	logic        held_nxt;
	logic        pend_r;
	logic        pend_nxt;
	logic [2:0]  halt_r;
	logic [2:0]  halt_nxt;
	logic        wreq_r;
	logic        wreq_nxt;
	logic        sync1_r;
	logic        sync2_r;
	logic        arm_r;
	logic        depth_r;
	logic [7:0]  trim_r;
	logic [7:0]  rdata_r;
	logic        osc_on_nxt;
	logic        ext_osc_r;
	logic        rc_osc_r;
	logic        periph_r;
	logic        wdt_osc_r;
	logic        halt_out_r;
	logic        res_irq_r;
	logic        res_plain_r;
	logic        res_reset_r;
	logic        res_irq_nxt;
	logic        res_plain_nxt;
	logic        res_reset_nxt;

	// ----------------------------------------------------------------
	// register decode
	// ----------------------------------------------------------------
	// only these two addresses belong here; the rest of i/o space is left alone
	wire        ctl_hit  = bus.io_addr == `SWK_CTL_ADDR;
	wire        trim_hit = bus.io_addr == `SWK_TRIM_ADDR;
	wire        ctl_wr   = bus.io_wr & ctl_hit;
	wire        trim_wr  = bus.io_wr & trim_hit;
	wire [7:0]  ctl_view = {2'b00, arm_r, depth_r, 4'h0};
	wire [7:0]  rd_sel   = ctl_hit ? ctl_view : (trim_hit ? trim_r : 8'h00);

	// ----------------------------------------------------------------
	// wake sources and timing selection
	// ----------------------------------------------------------------
	// sleep only when armed; otherwise the instruction is a no-op
	wire        sleep_go   = bus.sleep_exec & arm_r & (st_r == S_RUN);
	// idle keeps the interrupt system alive, so any request wakes
	wire        idle_wake  = ext_level_wake | pin_change_wake | timer_irq
	                         | comp_irq | other_irq;
	wire        any_reset  = ext_reset_req | wdt_reset_req;
	// power-down honours only external/watchdog reset, level and pin change
	wire        pd_reset   = ext_reset_req | (wdt_reset_req & wdt_enabled);
	wire        pd_cond    = ext_level_wake | pin_change_wake;
	wire        rc_sel     = clock_source_fuses[`SWK_FUSE_RC_BIT];
	wire        sleeping   = (st_r != S_RUN) && (st_r != S_HALT);
	wire        reset_wake = sleeping && ((st_r == S_IDLE) ? any_reset : pd_reset);

	// start-up delay follows the clock source fuses
	wire swk_tick_t per_sel =
		(clock_source_fuses[1:0] == 2'b00) ? `SWK_WAKE_PER0 :
		(clock_source_fuses[1:0] == 2'b01) ? `SWK_WAKE_PER1 :
		(clock_source_fuses[1:0] == 2'b10) ? `SWK_WAKE_PER2 :
		                                     `SWK_WAKE_PER3;
	// a period under two ticks replaces the two-tick qualification
	wire swk_tick_t qual_len =
		(per_sel < `SWK_QUAL_TICKS) ? per_sel : `SWK_QUAL_TICKS;
	wire        accepted = cnt_r >= qual_len;
	wire        per_done = cnt_r >= per_sel;

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb
	begin
		st_nxt        = st_r;
		cnt_nxt       = cnt_r;
		held_nxt      = held_r;
		pend_nxt      = pend_r;
		halt_nxt      = halt_r;
		wreq_nxt      = wreq_r;
		res_irq_nxt   = 1'b0;
		res_plain_nxt = 1'b0;
		res_reset_nxt = 1'b0;
		if (reset_wake)
		begin
			// restart from the vector, no handler, no halt window
			st_nxt        = S_RUN;
			res_reset_nxt = 1'b1;
			wreq_nxt      = 1'b0;
			pend_nxt      = 1'b0;
		end
		else
		begin
			unique case (st_r)
				S_RUN:
				begin
					if (sleep_go)
						st_nxt = depth_r ? S_PDOWN : S_IDLE;
				end
				S_IDLE:
				begin
					if (idle_wake)
					begin
						st_nxt   = S_HALT;
						pend_nxt = 1'b1;
						halt_nxt = `SWK_HALT_CYC - 3'h1;
					end
				end
				S_PDOWN:
				begin
					if (pd_cond)
					begin
						st_nxt   = S_QUAL;
						cnt_nxt  = '0;
						held_nxt = 1'b1;
					end
				end
				S_QUAL:
				begin
					// counted on watchdog oscillator ticks, not on mclk
					if (wdt_tick)
						cnt_nxt = cnt_r + 11'h001;
					held_nxt = held_r & pd_cond;
					if (!pd_cond && !accepted)
						st_nxt = S_PDOWN;
					else if (per_done)
					begin
						st_nxt   = S_SYNC;
						wreq_nxt = 1'b1;
						pend_nxt = held_r & pd_cond;
					end
				end
				S_SYNC:
				begin
					// clock restarts only once the request is synchronised
					if (sync2_r)
					begin
						st_nxt   = S_HALT;
						wreq_nxt = 1'b0;
						halt_nxt = `SWK_HALT_CYC - 3'h1;
					end
				end
				S_HALT:
				begin
					if (halt_r == 3'h0)
					begin
						st_nxt        = S_RUN;
						res_irq_nxt   = pend_r;
						res_plain_nxt = ~pend_r;
						pend_nxt      = 1'b0;
					end
					else
						halt_nxt = halt_r - 3'h1;
				end
				// two of the eight codes are unused; fall back to run
				default:
					st_nxt = S_RUN;
			endcase
		end
	end

	// oscillator stays stopped from power-down until the synchronised wake or a reset wake
	assign osc_on_nxt = (st_nxt != S_PDOWN) && (st_nxt != S_QUAL)
	                    && (st_nxt != S_SYNC);

	// ----------------------------------------------------------------
	// sequencer registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			st_r   <= S_RUN;
			cnt_r  <= '0;
			held_r <= 1'b0;
			pend_r <= 1'b0;
			halt_r <= 3'h0;
			wreq_r <= 1'b0;
		end
		else
		begin
			st_r   <= st_nxt;
			cnt_r  <= cnt_nxt;
			held_r <= held_nxt;
			pend_r <= pend_nxt;
			halt_r <= halt_nxt;
			wreq_r <= wreq_nxt;
		end
	end

	// two-stage synchroniser; only sync2_r is looked at
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
		end
		else
		begin
			sync1_r <= wreq_r;
			sync2_r <= sync1_r;
		end
	end

	// ----------------------------------------------------------------
	// software registers; sleep never clears them
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			arm_r   <= 1'b0;
			depth_r <= 1'b0;
			trim_r  <= `SWK_TRIM_RST;
			rdata_r <= 8'h00;
		end
		else
		begin
			if (ctl_wr)
			begin
				arm_r   <= bus.io_wdata[`SWK_CTL_ARM_BIT];
				depth_r <= bus.io_wdata[`SWK_CTL_DEP_BIT];
			end
			if (trim_wr)
				trim_r <= bus.io_wdata;
			rdata_r <= bus.io_rd ? rd_sel : 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			ext_osc_r   <= 1'b0;
			rc_osc_r    <= 1'b0;
			periph_r    <= 1'b0;
			wdt_osc_r   <= 1'b0;
			halt_out_r  <= 1'b0;
			res_irq_r   <= 1'b0;
			res_plain_r <= 1'b0;
			res_reset_r <= 1'b0;
		end
		else
		begin
			ext_osc_r   <= osc_on_nxt & ~rc_sel;
			rc_osc_r    <= osc_on_nxt & rc_sel;
			periph_r    <= osc_on_nxt;
			wdt_osc_r   <= 1'b1;
			halt_out_r  <= st_nxt != S_RUN;
			res_irq_r   <= res_irq_nxt;
			res_plain_r <= res_plain_nxt;
			res_reset_r <= res_reset_nxt;
		end
	end

	// trim drives the oscillator directly; higher code, higher frequency
	assign rc_trim          = trim_r;
	assign ext_osc_en       = ext_osc_r;
	assign rc_osc_en        = rc_osc_r;
	assign wdt_osc_en       = wdt_osc_r;
	assign periph_clk_en    = periph_r;
	assign bus.io_rdata     = rdata_r;
	assign bus.cpu_halt     = halt_out_r;
	assign bus.resume_irq   = res_irq_r;
	assign bus.resume_plain = res_plain_r;
	assign bus.resume_reset = res_reset_r;

endmodule

// ### core/swk_core.sv
// processor core end: arms sleep, issues it, writes trim
`include "swk_regs.svh"

module swk_core
	import swk_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst_b,
	swk_if.core             bus,
	input  wire logic       req_sleep,
	input  wire logic       req_depth,
	input  wire logic       comp_wake_needed,
	input  wire logic       req_trim,
	input  wire logic [7:0] trim_val,
	input  wire logic       nvm_write_mode,
	input  wire logic       req_read,
	input  wire logic [5:0] read_addr,
	output logic [7:0]      read_data,
	output logic            read_valid,
	output logic            core_asleep,
	output logic            handler_start,
	output logic            restart_vector,
	output logic            comparator_off
);

	swk_core_st_e st_r;
	logic         wr_r;
	logic         rd_r;
	logic [5:0]   addr_r;
	logic [7:0]   wdata_r;
	logic         exec_r;
	logic         rd_p1_r;
	logic [7:0]   rdat_r;
	logic         rval_r;
	logic         asleep_r;
	logic         hstart_r;
	logic         rvec_r;
	logic         cmp_off_r;

	// ----------------------------------------------------------------
	// request decode
	// ----------------------------------------------------------------
	// trim is clamped while nvm writes depend on the oscillator
	wire       trim_hi  = nvm_write_mode && (trim_val > `SWK_TRIM_NVM_MAX);
	wire [7:0] trim_w   = trim_hi ? `SWK_TRIM_NVM_MAX : trim_val;
	wire       resumed  = bus.resume_irq | bus.resume_plain | bus.resume_reset;
	wire [7:0] ctl_arm  = 8'h00 | (8'h01 << `SWK_CTL_ARM_BIT)
	                      | ({7'h00, req_depth} << `SWK_CTL_DEP_BIT);

	// ----------------------------------------------------------------
	// sequencer: arm, execute, wait, disarm
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			st_r      <= H_READY;
			wr_r      <= 1'b0;
			rd_r      <= 1'b0;
			addr_r    <= 6'h00;
			wdata_r   <= 8'h00;
			exec_r    <= 1'b0;
			cmp_off_r <= 1'b0;
		end
		else
		begin
			wr_r   <= 1'b0;
			rd_r   <= 1'b0;
			exec_r <= 1'b0;
			unique case (st_r)
				H_READY:
				begin
					if (req_sleep)
					begin
						// arm just before sleeping so a stray sleep stays harmless
						wr_r      <= 1'b1;
						addr_r    <= `SWK_CTL_ADDR;
						wdata_r   <= ctl_arm;
						cmp_off_r <= ~req_depth & ~comp_wake_needed;
						st_r      <= H_EXEC;
					end
					else if (req_trim)
					begin
						wr_r    <= 1'b1;
						addr_r  <= `SWK_TRIM_ADDR;
						wdata_r <= trim_w;
					end
					else if (req_read)
					begin
						rd_r   <= 1'b1;
						addr_r <= read_addr;
						st_r   <= H_READ;
					end
				end
				H_EXEC:
				begin
					exec_r <= 1'b1;
					st_r   <= H_WAIT;
				end
				H_WAIT:
				begin
					if (resumed)
					begin
						wr_r      <= 1'b1;
						addr_r    <= `SWK_CTL_ADDR;
						wdata_r   <= 8'h00;
						cmp_off_r <= 1'b0;
						st_r      <= H_DISARM;
					end
				end
				H_DISARM:
					st_r <= H_READY;
				H_READ:
					if (rd_p1_r)
						st_r <= H_READY;
				default:
					st_r <= H_READY;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read capture and status outputs
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			rd_p1_r  <= 1'b0;
			rdat_r   <= 8'h00;
			rval_r   <= 1'b0;
			asleep_r <= 1'b0;
			hstart_r <= 1'b0;
			rvec_r   <= 1'b0;
		end
		else
		begin
			rd_p1_r  <= rd_r;
			rval_r   <= rd_p1_r;
			if (rd_p1_r)
				rdat_r <= bus.io_rdata;
			asleep_r <= bus.cpu_halt;
			hstart_r <= bus.resume_irq;
			rvec_r   <= bus.resume_reset;
		end
	end

	assign bus.io_wr      = wr_r;
	assign bus.io_rd      = rd_r;
	assign bus.io_addr    = addr_r;
	assign bus.io_wdata   = wdata_r;
	assign bus.sleep_exec = exec_r;
	assign read_data      = rdat_r;
	assign read_valid     = rval_r;
	assign core_asleep    = asleep_r;
	assign handler_start  = hstart_r;
	assign restart_vector = rvec_r;
	assign comparator_off = cmp_off_r;

endmodule

// ### tb/swk_asserts.sv
// concurrent checks on the core-to-controller link
`include "swk_regs.svh"

module swk_asserts
(
	input wire logic       mclk,
	input wire logic       rst_b,
	input wire logic       io_wr,
	input wire logic       io_rd,
	input wire logic [5:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata,
	input wire logic       sleep_exec,
	input wire logic       cpu_halt,
	input wire logic       resume_irq,
	input wire logic       resume_plain,
	input wire logic       resume_reset
);
	timeunit 1ns;
	timeprecision 1ns;

	logic       arm_r;
	logic       dep_r;
	logic [7:0] trim_r;
	wire        any_res = resume_irq | resume_plain | resume_reset;
	wire        wr_ctl  = io_wr && io_addr == `SWK_CTL_ADDR;
	wire        wr_trim = io_wr && io_addr == `SWK_TRIM_ADDR;
	wire        rd_map  = io_addr == `SWK_CTL_ADDR || io_addr == `SWK_TRIM_ADDR;

	// shadow of the last writes, so read data can be predicted
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			arm_r  <= 1'b0;
			dep_r  <= 1'b0;
			trim_r <= 8'h00;
		end
		else
		begin
			if (wr_ctl)
			begin
				arm_r <= io_wdata[`SWK_CTL_ARM_BIT];
				dep_r <= io_wdata[`SWK_CTL_DEP_BIT];
			end
			if (wr_trim)
				trim_r <= io_wdata;
		end
	end

	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	property p_enter;
		sleep_exec && arm_r && !cpu_halt |=> cpu_halt;
	endproperty
	a_enter: assert property (p_enter) else $error("armed sleep did not halt");

	property p_halt4;
		resume_irq |-> !cpu_halt && $past(cpu_halt, 4);
	endproperty
	a_halt4: assert property (p_halt4) else $error("short halt before resume");

	property p_pulse;
		any_res |-> !cpu_halt ##1 !any_res;
	endproperty
	a_pulse: assert property (p_pulse) else $error("resume not a lone pulse");

	property p_fall;
		$fell(cpu_halt) |-> $onehot(any_res ? {resume_irq, resume_plain, resume_reset} : 3'h0);
	endproperty
	a_fall: assert property (p_fall) else $error("halt left without one resume");

	property p_from_sleep;
		any_res |-> $past(cpu_halt);
	endproperty
	a_from_sleep: assert property (p_from_sleep) else $error("resume while running");

	property p_unmapped;
		io_rd && !rd_map |=> io_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

	property p_trim_rd;
		io_rd && io_addr == `SWK_TRIM_ADDR |=> io_rdata == trim_r;
	endproperty
	a_trim_rd: assert property (p_trim_rd) else $error("trim read differs");

	property p_ctl_rd;
		io_rd && io_addr == `SWK_CTL_ADDR |=> io_rdata == {2'h0, arm_r, dep_r, 4'h0};
	endproperty
	a_ctl_rd: assert property (p_ctl_rd) else $error("control read differs");

	c_irq: cover property (resume_irq);
	c_plain: cover property (resume_plain);
	c_reset: cover property (resume_reset);
endmodule

// ### tb/test_sleep_wake_and_rc_trim.sv
// self-checking bench for the core and sleep controller pair
`include "swk_regs.svh"

module test_sleep_wake_and_rc_trim;
	timeunit 1ns;
	timeprecision 1ns;

	logic       mclk, rst_b, req_sleep, req_depth, comp_wake_needed;
	logic       req_trim, nvm_write_mode, req_read, read_valid, core_asleep;
	logic       handler_start, restart_vector, comparator_off, wdt_enabled;
	logic       wdt_tick, ext_osc_en, rc_osc_en, wdt_osc_en, periph_clk_en;
	logic       got_h, got_r, nv;
	logic [7:0] trim_val, read_data, rc_trim, last_trim, rd, v;
	logic [5:0] read_addr;
	logic [4:0] wk;
	logic [1:0] rq, tick_cnt;
	logic [2:0] fuses;
	integer     seed, n_mismatch, cmp_count, k, waited;

	swk_if swk_bus();

	swk_dev u_swk_dev (.mclk(mclk), .rst_b(rst_b), .bus(swk_bus),
		.ext_level_wake(wk[3]), .pin_change_wake(wk[4]), .timer_irq(wk[0]),
		.comp_irq(wk[1]), .other_irq(wk[2]), .ext_reset_req(rq[0]),
		.wdt_reset_req(rq[1]), .wdt_enabled(wdt_enabled), .wdt_tick(wdt_tick),
		.clock_source_fuses(fuses), .ext_osc_en(ext_osc_en), .rc_osc_en(rc_osc_en),
		.wdt_osc_en(wdt_osc_en), .periph_clk_en(periph_clk_en), .rc_trim(rc_trim));

	swk_core u_swk_core (.mclk(mclk), .rst_b(rst_b), .bus(swk_bus),
		.req_sleep(req_sleep), .req_depth(req_depth),
		.comp_wake_needed(comp_wake_needed), .req_trim(req_trim),
		.trim_val(trim_val), .nvm_write_mode(nvm_write_mode), .req_read(req_read),
		.read_addr(read_addr), .read_data(read_data), .read_valid(read_valid),
		.core_asleep(core_asleep), .handler_start(handler_start),
		.restart_vector(restart_vector), .comparator_off(comparator_off));

	swk_asserts u_swk_asserts (.mclk(mclk), .rst_b(rst_b), .io_wr(swk_bus.io_wr),
		.io_rd(swk_bus.io_rd), .io_addr(swk_bus.io_addr), .io_wdata(swk_bus.io_wdata),
		.io_rdata(swk_bus.io_rdata), .sleep_exec(swk_bus.sleep_exec),
		.cpu_halt(swk_bus.cpu_halt), .resume_irq(swk_bus.resume_irq),
		.resume_plain(swk_bus.resume_plain), .resume_reset(swk_bus.resume_reset));

	// ----------------------------------------
	// clock, watchdog ticks, helpers
	// ----------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// slow oscillator stand-in: one tick every fourth mclk
	always @(posedge mclk)
	begin
		tick_cnt <= tick_cnt + 2'h1;
		wdt_tick <= tick_cnt == 2'h3;
	end

	function automatic logic [7:0] exp_trim(input logic [7:0] t, input logic n);
		return (n && t > `SWK_TRIM_NVM_MAX) ? `SWK_TRIM_NVM_MAX : t;
	endfunction

	function automatic int per(input int f);
		return (f == 0) ? 1 : (f == 1) ? 16 : (f == 2) ? 256 : 1024;
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count = cmp_count + 1;
		if (got !== exp)
		begin
			n_mismatch = n_mismatch + 1;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// pulse a core request, then wait up to eight cycles for read_valid
	task automatic do_read(input logic [5:0] a);
		int i;
		@(posedge mclk) req_read <= 1'b1;
		read_addr <= a;
		@(posedge mclk) req_read <= 1'b0;
		for (i = 0; i < 8 && read_valid !== 1'b1; i++)
			@(negedge mclk);
		rd = read_data;
	endtask

	task automatic do_sleep(input logic d, input logic cw);
		int i;
		@(posedge mclk) req_sleep <= 1'b1;
		req_depth <= d;
		comp_wake_needed <= cw;
		@(posedge mclk) req_sleep <= 1'b0;
		for (i = 0; i < 10 && core_asleep !== 1'b1; i++)
			@(negedge mclk);
	endtask

	// bounded wait for the core to leave sleep, noting how it left
	task automatic wait_wake(input int n);
		got_h = 1'b0;
		got_r = 1'b0;
		for (waited = 0; waited < n && core_asleep !== 1'b0; waited++)
		begin
			@(negedge mclk);
			got_h = got_h | handler_start;
			got_r = got_r | restart_vector;
		end
	endtask

	initial
	begin
		repeat (20000) @(posedge mclk);
		n_mismatch = n_mismatch + 1;
		test_done;
	end

	initial
	begin
		seed = 32'hb679;
		{n_mismatch, cmp_count, tick_cnt, wdt_tick, wk, rq} = 0;
		{req_sleep, req_depth, comp_wake_needed, req_trim, nvm_write_mode} = 5'h00;
		{req_read, read_addr, trim_val} = 15'h0000;
		wdt_enabled = 1'b1;
		fuses = 3'h4;
		rst_b = 1'b0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		// the release edge still sees reset low; enables come one edge later
		repeat (2) @(negedge mclk);
		chk(wdt_osc_en, 1'b1);
		chk({rc_osc_en, ext_osc_en}, 2'h2);
		do_read(`SWK_TRIM_ADDR);
		chk(rd, `SWK_TRIM_RST);
		do_read(6'h20);
		chk(rd, 8'h00);
		do_read(`SWK_CTL_ADDR);
		chk(rd, 8'h00);
		// random trims plus 8'hff and 8'hf0, the last two passes (8'hf0 and a random one) under nvm limits
		for (k = 0; k < 6; k++)
		begin
			v = (k == 0) ? 8'hff : (k == 4) ? 8'hf0 : 8'($random(seed));
			nv = k >= 4;
			@(posedge mclk) req_trim <= 1'b1;
			trim_val <= v;
			nvm_write_mode <= nv;
			@(posedge mclk) req_trim <= 1'b0;
			repeat (3) @(posedge mclk);
			last_trim = exp_trim(v, nv);
			do_read(`SWK_TRIM_ADDR);
			chk(rd, last_trim);
			chk(rc_trim, last_trim);
		end
		// idle: each of the five sources must wake it, handler runs
		for (k = 0; k < 5; k++)
		begin
			do_sleep(1'b0, k[0]);
			chk({core_asleep, periph_clk_en}, 2'h3);
			chk(comparator_off, !k[0]);
			@(posedge mclk) wk <= 5'h01 << k;
			wait_wake(20);
			@(posedge mclk) wk <= 5'h00;
			chk({got_h, got_r}, 2'h2);
			do_read(`SWK_TRIM_ADDR);
			chk(rd, last_trim);
		end
		// power-down over three fuse periods; peripheral irqs ignored
		for (k = 0; k < 3; k++)
		begin
			@(posedge mclk) fuses <= {k[0], k[1:0]};
			do_sleep(1'b1, 1'b1);
			chk({ext_osc_en, rc_osc_en, periph_clk_en}, 3'h0);
			chk(wdt_osc_en, 1'b1);
			@(posedge mclk) wk <= 5'h07;
			repeat (40) @(posedge mclk);
			wk <= 5'h00;
			if (k > 0)
			begin
				@(posedge mclk) wk <= 5'h10;
				@(posedge mclk) wk <= 5'h00;
				repeat (40) @(posedge mclk);
			end
			chk(core_asleep, 1'b1);
			@(posedge mclk) wk <= 5'h08; // held past the start-up delay
			wait_wake(4 * per(k) + 40);
			@(posedge mclk) wk <= 5'h00;
			chk({got_h, core_asleep}, 2'h2);
			chk(waited >= 4 * per(k) - 4, 1'b1);
			chk(k[0] ? rc_osc_en : ext_osc_en, 1'b1);
		end
		// condition lost after qualification but inside the period
		@(posedge mclk) fuses <= 3'h1;
		do_sleep(1'b1, 1'b1);
		@(posedge mclk) wk <= 5'h10;
		repeat (14) @(posedge mclk);
		wk <= 5'h00;
		wait_wake(120);
		chk({got_h, core_asleep}, 2'h0);
		// external reset in idle, watchdog reset in power-down
		for (k = 0; k < 2; k++)
		begin
			do_sleep(k[0], 1'b1);
			@(posedge mclk) rq <= 2'h1 << k;
			@(posedge mclk) rq <= 2'h0;
			wait_wake(20);
			chk({got_r, got_h}, 2'h2);
		end
		// core disarms after every wake, so a stray sleep stays harmless
		do_read(`SWK_CTL_ADDR);
		chk(rd, 8'h00);
		test_done;
	end
endmodule
